// ==== rtl/sdram_seq.sv ====
// four-bank sdram command sequencer: request buffer, bank trackers, pins
// assumes memory clocked by clk_in and requests from same-clock logic
`timescale 1ns/100ps

// What this block does
// - idle cycles drive nop so operations in progress continue
// - commands to any bank are judged by that bank's own tracker
// - act, read, write, precharge may go to other banks while one is busy
// - refresh, self refresh and mode load only when all banks idle
// - burst terminate only while a non-autoprecharge burst runs
// - write ending a read has data mask one clock before
// - read ends a write when registered, data cas latency later
// - write interrupting read-autoprecharge needs mask two clocks before
// - clock enable fall enters power-down, self refresh or suspend
// - power-down exit with nop, commands from the next edge
// - self refresh exit with nops through exit time, at least two
// - commands never legal are refused, as is any but wake in power-down or self refresh; others wait until legal
module sdram_seq #(
  parameter int BURST_LEN = 4
) (
  // clock, reset, enable
  input  wire logic                          clk_in,
  input  wire logic                          rst_in,
  input  wire logic                          ce_in,
  // request stream
  input  wire logic                          req_valid_in,
  input  wire sdram_pkg::req_t               req_in,
  output logic                               req_ready_out,
  output logic                               reject_out,
  input  wire logic                          suspend_in,
  output logic                               all_idle_out,
  // memory pins
  output sdram_pkg::pins_t                   pins_out,
  output logic [sdram_pkg::BANK_W-1:0]       ba_out,
  output logic [sdram_pkg::ADDR_W-1:0]       addr_out,
  output logic                               dqm_out,
  output logic                               cke_out
);
  localparam int NB = 4;
  localparam sdram_pkg::tmr_t BL_C = sdram_pkg::tmr_t'(BURST_LEN);

  sdram_pkg::req_t   mem_q [2];
  logic              wp_q;
  logic              rp_q;
  logic [1:0]        cnt_q;
  logic [1:0]        cnt_d;
  logic              push;
  logic              pop;
  sdram_pkg::req_t   head;
  logic              head_valid;
  sdram_pkg::bank_t  st_q [NB];
  sdram_pkg::tmr_t   tm_q [NB];
  logic [NB-1:0]     ap_q;
  sdram_pkg::tmr_t   gbusy_q;
  sdram_pkg::tmr_t   gbusy_d;
  sdram_pkg::power_t pw_q;
  sdram_pkg::power_t pw_d;
  logic [1:0]        dqm_cnt_q;
  logic [1:0]        dqm_cnt_d;
  logic [1:0]        need;
  sdram_pkg::pins_t  pins_d;
  logic [sdram_pkg::ADDR_W-1:0] addr_d;
  logic              dqm_d;
  logic              cke_d;
  logic              rej_d;
  logic              issue;
  logic              all_idle;
  logic              rd_any;
  logic              rd_ap_any;
  logic              burst_any;
  logic              bst_ok;
  logic              pre_all_ok;
  logic              quiet;
  logic              legal;
  logic              out_nop;

  // precharge legal without cutting an autoprecharge burst
  function automatic logic pre_ok(sdram_pkg::bank_t s, logic ap);
    pre_ok = (s == sdram_pkg::bk_idle) || (s == sdram_pkg::bk_open) ||
             (((s == sdram_pkg::bk_rd) || (s == sdram_pkg::bk_wr)) && !ap);
  endfunction

  function automatic logic is_burst(sdram_pkg::bank_t s);
    is_burst = (s == sdram_pkg::bk_rd) || (s == sdram_pkg::bk_wr);
  endfunction

  // two-entry request buffer; a stalled head keeps back-pressure honest
  assign push       = req_valid_in && req_ready_out;
  assign head       = mem_q[rp_q];
  assign head_valid = (cnt_q != 2'h0);
  assign cnt_d      = cnt_q + {1'b0, push} - {1'b0, pop};

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wp_q          <= 1'b0;
      rp_q          <= 1'b0;
      cnt_q         <= 2'h0;
      req_ready_out <= 1'b0;
    end else if (ce_in) begin
      if (push) begin
        wp_q <= !wp_q;
      end
      if (pop) begin
        rp_q <= !rp_q;
      end
      cnt_q         <= cnt_d;
      req_ready_out <= (cnt_d != 2'h2);
    end
  end

  always_ff @(posedge clk_in) begin
    if (ce_in && push) begin
      mem_q[wp_q] <= req_in;
    end
  end

  always_comb begin
    all_idle   = (gbusy_q == sdram_pkg::TMR_RST);
    rd_any     = 1'b0;
    rd_ap_any  = 1'b0;
    burst_any  = 1'b0;
    bst_ok     = 1'b0;
    pre_all_ok = 1'b1;
    quiet      = (gbusy_q == sdram_pkg::TMR_RST);
    for (int i = 0; i < NB; i++) begin
      all_idle   = all_idle && (st_q[i] == sdram_pkg::bk_idle);
      rd_any     = rd_any || (st_q[i] == sdram_pkg::bk_rd);
      rd_ap_any  = rd_ap_any || ((st_q[i] == sdram_pkg::bk_rd) && ap_q[i]);
      burst_any  = burst_any || is_burst(st_q[i]);
      bst_ok     = bst_ok || (is_burst(st_q[i]) && !ap_q[i]);
      pre_all_ok = pre_all_ok && pre_ok(st_q[i], ap_q[i]);
      quiet      = quiet && ((st_q[i] == sdram_pkg::bk_idle) ||
                             (st_q[i] == sdram_pkg::bk_open));
    end
    need = rd_ap_any ? sdram_pkg::DQM_LEAD_RDAP :
           (rd_any ? sdram_pkg::DQM_LEAD_RD : 2'h0);
  end

  // target-bank check for act, read, write and single-bank precharge; others look at all banks
  always_comb begin
    case (head.op)
      sdram_pkg::op_act: legal = (st_q[head.bank] == sdram_pkg::bk_idle);
      sdram_pkg::op_rd,
      sdram_pkg::op_wr: legal = (st_q[head.bank] == sdram_pkg::bk_open) ||
                        (is_burst(st_q[head.bank]) && !ap_q[head.bank]);
      sdram_pkg::op_pre: legal = head.ap ? pre_all_ok :
                         pre_ok(st_q[head.bank], ap_q[head.bank]);
      sdram_pkg::op_ref,
      sdram_pkg::op_lmr: legal = all_idle;
      // terminate only a running plain burst
      sdram_pkg::op_bst: legal = bst_ok;
      default: legal = 1'b0;
    endcase
  end

  always_comb begin
    pins_d    = sdram_pkg::P_NOP;
    addr_d    = '0;
    dqm_d     = 1'b0;
    cke_d     = cke_out;
    pop       = 1'b0;
    rej_d     = 1'b0;
    issue     = 1'b0;
    pw_d      = pw_q;
    dqm_cnt_d = 2'h0;
    gbusy_d   = (gbusy_q != sdram_pkg::TMR_RST) ? gbusy_q - 8'h01 : gbusy_q;
    case (pw_q)
      sdram_pkg::pw_on: begin
        if (suspend_in && burst_any) begin
          cke_d = 1'b0;
          pw_d  = sdram_pkg::pw_susp;
        // only with clock enable high and no exit wait
        end else if (head_valid && cke_out &&
                     gbusy_q == sdram_pkg::TMR_RST) begin
          if (head.op == sdram_pkg::op_nop ||
              head.op == sdram_pkg::op_wake) begin
            pop = 1'b1;
          end else if (head.op == sdram_pkg::op_pdn ||
                       head.op == sdram_pkg::op_sref) begin
            // power-down with nop, self refresh with refresh
            if (all_idle) begin
              pop    = 1'b1;
              cke_d  = 1'b0;
              pins_d = (head.op == sdram_pkg::op_sref) ? sdram_pkg::P_REF :
                       sdram_pkg::P_NOP;
              pw_d   = (head.op == sdram_pkg::op_sref) ? sdram_pkg::pw_sref :
                       sdram_pkg::pw_pdown;
            end else if (quiet) begin
              pop   = 1'b1;
              rej_d = 1'b1;
            end
          end else if (legal) begin
            if (head.op == sdram_pkg::op_wr && dqm_cnt_q < need) begin
              // mask lead before a write that cuts a read
              dqm_d     = 1'b1;
              dqm_cnt_d = dqm_cnt_q + 2'h1;
            end else begin
              pop    = 1'b1;
              issue  = 1'b1;
              addr_d = head.addr;
              addr_d[sdram_pkg::AP_BIT] = head.ap;
              case (head.op)
                sdram_pkg::op_act: begin
                  pins_d = sdram_pkg::P_ACT;
                  addr_d = head.addr;
                end
                sdram_pkg::op_rd:  pins_d = sdram_pkg::P_RD;
                sdram_pkg::op_wr:  pins_d = sdram_pkg::P_WR;
                sdram_pkg::op_pre: pins_d = sdram_pkg::P_PRE;
                sdram_pkg::op_ref: begin
                  pins_d  = sdram_pkg::P_REF;
                  gbusy_d = sdram_pkg::RFC_C;
                end
                sdram_pkg::op_lmr: begin
                  pins_d  = sdram_pkg::P_LMR;
                  addr_d  = head.addr;
                  gbusy_d = sdram_pkg::MRD_C;
                end
                sdram_pkg::op_bst: pins_d = sdram_pkg::P_BST;
                default:           pins_d = sdram_pkg::P_NOP;
              endcase
            end
          // a command that waiting cannot make legal is dropped
          end else if (quiet) begin
            pop   = 1'b1;
            rej_d = 1'b1;
          end
        end
      end
      sdram_pkg::pw_pdown,
      sdram_pkg::pw_sref: begin
        // clock enable stays low until a wake request
        if (head_valid) begin
          pop = 1'b1;
          if (head.op == sdram_pkg::op_wake) begin
            // exit with nop; self refresh adds the exit wait
            cke_d = 1'b1;
            pw_d  = sdram_pkg::pw_on;
            if (pw_q == sdram_pkg::pw_sref) begin
              gbusy_d = sdram_pkg::XSR_C;
            end
          end else begin
            rej_d = 1'b1;
          end
        end
      end
      sdram_pkg::pw_susp: begin
        // resume; next command may follow on the next edge
        if (!suspend_in) begin
          cke_d = 1'b1;
          pw_d  = sdram_pkg::pw_on;
        end
      end
      default: pw_d = sdram_pkg::pw_on;
    endcase
  end

  // nop on every edge with nothing to send
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pins_out     <= sdram_pkg::P_INH;
      ba_out       <= '0;
      addr_out     <= '0;
      dqm_out      <= 1'b0;
      cke_out      <= sdram_pkg::CKE_RST;
      reject_out   <= 1'b0;
      all_idle_out <= 1'b1;
      pw_q         <= sdram_pkg::pw_on;
      gbusy_q      <= sdram_pkg::TMR_RST;
      dqm_cnt_q    <= 2'h0;
    end else if (ce_in) begin
      pins_out     <= pins_d;
      ba_out       <= head.bank;
      addr_out     <= addr_d;
      dqm_out      <= dqm_d;
      cke_out      <= cke_d;
      reject_out   <= rej_d;
      all_idle_out <= all_idle;
      pw_q         <= pw_d;
      gbusy_q      <= gbusy_d;
      dqm_cnt_q    <= dqm_cnt_d;
    end
  end

  assign out_nop = pins_out.cs_n || (pins_out == sdram_pkg::P_NOP);

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // per-bank trackers; suspend freezes them as the memory freezes
  for (genvar g = 0; g < NB; g++) begin : g_bank
    logic hit;
    logic rdwr;
    assign hit  = issue && (head.bank == g);
    assign rdwr = issue && (head.op == sdram_pkg::op_rd ||
                            head.op == sdram_pkg::op_wr);
    always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
        st_q[g] <= sdram_pkg::bk_idle;
        tm_q[g] <= sdram_pkg::TMR_RST;
        ap_q[g] <= 1'b0;
      end else if (ce_in && pw_q != sdram_pkg::pw_susp) begin
        if (hit && head.op == sdram_pkg::op_act) begin
          st_q[g] <= sdram_pkg::bk_act;
          tm_q[g] <= sdram_pkg::RCD_C;
        end else if (hit && rdwr) begin
          st_q[g] <= (head.op == sdram_pkg::op_rd) ? sdram_pkg::bk_rd :
                     sdram_pkg::bk_wr;
          tm_q[g] <= BL_C;
          ap_q[g] <= head.ap;
        // a precharge elsewhere leaves this burst alone
        end else if (issue && head.op == sdram_pkg::op_pre &&
                     (hit || head.ap) && st_q[g] != sdram_pkg::bk_idle) begin
          st_q[g] <= sdram_pkg::bk_pre;
          tm_q[g] <= sdram_pkg::RP_C;
        // read cut by another bank's burst
        end else if (rdwr && st_q[g] == sdram_pkg::bk_rd) begin
          st_q[g] <= ap_q[g] ? sdram_pkg::bk_pre : sdram_pkg::bk_open;
          tm_q[g] <= sdram_pkg::RP_C;
        // write cut; recovery counts from the new command
        end else if (rdwr && st_q[g] == sdram_pkg::bk_wr) begin
          st_q[g] <= ap_q[g] ? sdram_pkg::bk_wrrec : sdram_pkg::bk_open;
          tm_q[g] <= sdram_pkg::WR_C;
        // terminate ends only a plain burst
        end else if (issue && head.op == sdram_pkg::op_bst &&
                     is_burst(st_q[g]) && !ap_q[g]) begin
          st_q[g] <= sdram_pkg::bk_open;
        end else if (tm_q[g] > 8'h01) begin
          tm_q[g] <= tm_q[g] - 8'h01;
        end else begin
          tm_q[g] <= sdram_pkg::RP_C;
          case (st_q[g])
            sdram_pkg::bk_act: st_q[g] <= sdram_pkg::bk_open;
            sdram_pkg::bk_rd:  st_q[g] <= ap_q[g] ? sdram_pkg::bk_pre :
                                          sdram_pkg::bk_open;
            sdram_pkg::bk_wr: begin
              st_q[g] <= ap_q[g] ? sdram_pkg::bk_wrrec : sdram_pkg::bk_open;
              tm_q[g] <= sdram_pkg::WR_C;
            end
            sdram_pkg::bk_wrrec: st_q[g] <= sdram_pkg::bk_pre;
            sdram_pkg::bk_pre:   st_q[g] <= sdram_pkg::bk_idle;
            default:             st_q[g] <= st_q[g];
          endcase
        end
      end
    end

    property p_rdap_pre;
      ce_in && rdwr && !hit && st_q[g] == sdram_pkg::bk_rd && ap_q[g]
        |=> st_q[g] == sdram_pkg::bk_pre && tm_q[g] == sdram_pkg::RP_C;
    endproperty
    a_rdap_pre: assert property (p_rdap_pre)
      else $error("interrupted read-ap bank did not start precharge");

    property p_wrap_rec;
      ce_in && rdwr && !hit && st_q[g] == sdram_pkg::bk_wr && ap_q[g]
        |=> st_q[g] == sdram_pkg::bk_wrrec && tm_q[g] == sdram_pkg::WR_C;
    endproperty
    a_wrap_rec: assert property (p_wrap_rec)
      else $error("interrupted write-ap bank skipped write recovery");

    property p_act_idle;
      ce_in && hit && head.op == sdram_pkg::op_act
        |-> st_q[g] == sdram_pkg::bk_idle ##1 st_q[g] == sdram_pkg::bk_act;
    endproperty
    a_act_idle: assert property (p_act_idle)
      else $error("activate sent to a bank that was not idle");
  end

  property p_gbusy_nop;
    gbusy_q != sdram_pkg::TMR_RST && pw_q == sdram_pkg::pw_on |=> out_nop;
  endproperty
  a_gbusy_nop: assert property (p_gbusy_nop)
    else $error("command sent during refresh or exit wait");

  property p_ref_idle;
    cke_out && !pins_out.cs_n &&
      (pins_out == sdram_pkg::P_REF || pins_out == sdram_pkg::P_LMR)
      |-> $past(all_idle);
  endproperty
  a_ref_idle: assert property (p_ref_idle)
    else $error("refresh or mode load with a bank not idle");

  property p_dqm1;
    issue && head.op == sdram_pkg::op_wr && rd_any |-> dqm_out;
  endproperty
  a_dqm1: assert property (p_dqm1)
    else $error("write cut a read without mask lead");

  property p_dqm2;
    issue && head.op == sdram_pkg::op_wr && rd_ap_any
      |-> dqm_out && $past(dqm_out);
  endproperty
  a_dqm2: assert property (p_dqm2)
    else $error("write cut read-ap without two-cycle mask lead");

  property p_bst;
    issue && head.op == sdram_pkg::op_bst |-> bst_ok;
  endproperty
  a_bst: assert property (p_bst)
    else $error("burst terminate without plain burst running");

  property p_cke_fall;
    $fell(cke_out) |-> $past(all_idle) || $past(burst_any);
  endproperty
  a_cke_fall: assert property (p_cke_fall)
    else $error("clock enable dropped outside idle or burst");

  property p_cke_rise;
    $rose(cke_out) |-> out_nop;
  endproperty
  a_cke_rise: assert property (p_cke_rise)
    else $error("clock enable raised without nop");

  property p_sref_exit;
    $rose(cke_out) && gbusy_q != sdram_pkg::TMR_RST
      |-> out_nop ##1 out_nop ##1 out_nop;
  endproperty
  a_sref_exit: assert property (p_sref_exit)
    else $error("fewer than two nops after self refresh exit");

  c_dqm2: cover property (issue && head.op == sdram_pkg::op_wr && rd_ap_any);
  c_sref: cover property (pw_q == sdram_pkg::pw_sref ##1
                          pw_q == sdram_pkg::pw_on);
  c_susp: cover property (pw_q == sdram_pkg::pw_susp);
  c_rej:  cover property (reject_out);
endmodule

// ==== rtl/sdram_pkg.sv ====
// constants and carrier types for the four-bank sdram command sequencer
// assumes one 250 mhz clock shared by sequencer and memory
package sdram_pkg;
  localparam int CLK_MHZ   = 250;
  localparam int BANK_W    = 2;
  localparam int ADDR_W    = 13;
  localparam int TMR_W     = 8;
  localparam int AP_BIT    = 10;
  // device timings in ns; plain defaults, retune per speed grade
  localparam int T_RCD_NS  = 20;
  localparam int T_RP_NS   = 20;
  localparam int T_WR_NS   = 15;
  localparam int T_RFC_NS  = 66;
  localparam int T_MRD_NS  = 8;
  localparam int T_XSR_NS  = 67;
  localparam int XSR_MIN_NOPS = 2;
  // least times round up to whole cycles
  localparam int T_RCD_CYC = (T_RCD_NS * CLK_MHZ + 999) / 1000;
  localparam int T_RP_CYC  = (T_RP_NS * CLK_MHZ + 999) / 1000;
  localparam int T_WR_CYC  = (T_WR_NS * CLK_MHZ + 999) / 1000;
  localparam int T_RFC_CYC = (T_RFC_NS * CLK_MHZ + 999) / 1000;
  localparam int T_MRD_CYC = (T_MRD_NS * CLK_MHZ + 999) / 1000;
  localparam int XSR_RAW   = (T_XSR_NS * CLK_MHZ + 999) / 1000;
  localparam int T_XSR_CYC = (XSR_RAW < XSR_MIN_NOPS) ? XSR_MIN_NOPS : XSR_RAW;

  typedef logic [TMR_W-1:0] tmr_t;
  localparam tmr_t RCD_C = tmr_t'(T_RCD_CYC);
  localparam tmr_t RP_C  = tmr_t'(T_RP_CYC);
  localparam tmr_t WR_C  = tmr_t'(T_WR_CYC);
  localparam tmr_t RFC_C = tmr_t'(T_RFC_CYC);
  localparam tmr_t MRD_C = tmr_t'(T_MRD_CYC);
  localparam tmr_t XSR_C = tmr_t'(T_XSR_CYC);
  localparam tmr_t TMR_RST = 8'h00;
  localparam logic [1:0] DQM_LEAD_RD   = 2'h1;
  localparam logic [1:0] DQM_LEAD_RDAP = 2'h2;
  localparam logic CKE_RST = 1'h1;

  typedef enum logic [3:0] {
    op_nop, op_act, op_rd, op_wr, op_pre, op_ref, op_lmr, op_bst,
    op_pdn, op_sref, op_wake
  } op_t;

  typedef struct packed {
    op_t               op;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
    logic              ap;
  } req_t;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } pins_t;

  localparam pins_t P_INH = 4'hf;
  localparam pins_t P_NOP = 4'h7;
  localparam pins_t P_ACT = 4'h3;
  localparam pins_t P_RD  = 4'h5;
  localparam pins_t P_WR  = 4'h4;
  localparam pins_t P_PRE = 4'h2;
  localparam pins_t P_REF = 4'h1;
  localparam pins_t P_LMR = 4'h0;
  localparam pins_t P_BST = 4'h6;

  typedef enum logic [2:0] {
    bk_idle, bk_act, bk_open, bk_rd, bk_wr, bk_wrrec, bk_pre
  } bank_t;

  typedef enum logic [1:0] {pw_on, pw_pdown, pw_sref, pw_susp} power_t;
endpackage

// ==== testbench/sdram_model.sv ====
// sdram device stand-in: per-bank trackers, counts illegal commands
// assumes pins registered on clk_in, the shared memory clock
`timescale 1ns/100ps
module sdram_model #(
  parameter int BL = 4
) (
  // clock, reset
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  // memory pins
  input  wire sdram_pkg::pins_t pins_in,
  input  wire logic [1:0]       ba_in,
  input  wire logic             ap_in,
  input  wire logic             cke_in,
  // misuse count
  output int                    viol_out
);
  // bank state: 0 idle, 1 open, 2 precharging, 3 activating
  int st[4];
  int tm[4];
  int gt, bc, bb;
  int rp  = sdram_pkg::RP_C;
  int wrr = sdram_pkg::WR_C;
  bit bap, bwr, ck, sr, nop;
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      viol_out = 0;
      st = '{0, 0, 0, 0};
      tm = '{0, 0, 0, 0};
      gt = 0;
      bc = 0;
      ck = 1;
      sr = 0;
    end else begin
      nop = pins_in.cs_n || pins_in == sdram_pkg::P_NOP;
      if (ck) begin
        foreach (tm[i]) begin
          if (tm[i] == 1) st[i] -= 2;
          if (tm[i] > 0) tm[i]--;
        end
        if (gt > 0) gt--;
        if (bc > 0) bc--;
      end
      if (!ck && !nop) viol_out++;
      if (!ck && cke_in && sr) gt = sdram_pkg::XSR_C;
      if (!ck && cke_in) sr = 0;
      if (ck && !cke_in) begin
        if (pins_in == sdram_pkg::P_REF) sr = 1;
        if (bc == 0 && (st.sum() != 0 || gt > 0 || !(nop || sr))) viol_out++;
      end
      if (ck && cke_in && !nop) begin
        if (gt > 0) viol_out++;
        case (pins_in)
          sdram_pkg::P_ACT: begin
            if (st[ba_in] != 0) viol_out++;
            st[ba_in] = 3;
            tm[ba_in] = sdram_pkg::RCD_C;
          end
          sdram_pkg::P_RD, sdram_pkg::P_WR: begin
            if (st[ba_in] != 1) viol_out++;
            if (bc > 0 && bap) tm[bb] = rp + (bwr ? wrr : 0);
            bc = BL;
            bb = ba_in;
            bwr = pins_in == sdram_pkg::P_WR;
            bap = ap_in;
            if (bap) st[bb] = 2;
            if (bap) tm[bb] = BL + rp + (bwr ? wrr : 0);
          end
          sdram_pkg::P_PRE: begin
            foreach (st[i]) begin
              if (ap_in || i == ba_in) begin
                if (st[i] > 1) viol_out++;
                if (st[i] == 1) tm[i] = rp;
                if (st[i] == 1) st[i] = 2;
              end
            end
            if (ap_in || bb == ba_in) bc = 0;
          end
          sdram_pkg::P_REF, sdram_pkg::P_LMR: begin
            if (st.sum() != 0 || bc > 0) viol_out++;
            gt = pins_in == sdram_pkg::P_REF ? sdram_pkg::RFC_C : 2;
          end
          sdram_pkg::P_BST: begin
            if (bc == 0) viol_out++;
            bc = 0;
          end
          default: ;
        endcase
      end
      ck = cke_in;
    end
  end
endmodule

// ==== testbench/tb.sv ====
// bench for the sdram sequencer with a device stand-in on its pins
// assumes the rtl package and the stand-in are compiled first
`timescale 1ns/100ps
`define CHK(n, g, e) begin checks_done++; if ((g) !== (e)) begin \
  errors++; $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module tb;
  typedef struct packed {
    sdram_pkg::pins_t pins;
    logic [1:0]       bank;
    logic             ap;
    logic [1:0]       lead;
  } exp_t;
  logic                         clk_in = 0;
  logic                         rst_in = 1;
  logic                         req_valid_in = 0;
  logic                         suspend_in = 0;
  logic                         ce = 1;
  logic                         req_ready_out, reject_out, all_idle_out;
  logic                         dqm_out, cke_out, ap, wr;
  logic [1:0]                   dh = 0;
  logic [1:0]                   bk;
  sdram_pkg::req_t              req_in = '0;
  sdram_pkg::pins_t             pins_out;
  logic [sdram_pkg::BANK_W-1:0] ba_out;
  logic [sdram_pkg::ADDR_W-1:0] addr_out;
  exp_t                         expq[$];
  exp_t                         e;
  int                           seed = 89571;
  int                           viol, errors = 0, checks_done = 0;
  int                           rej_exp = 0, rej_seen = 0;
  always #2 clk_in = ~clk_in;
  sdram_seq #(.BURST_LEN(4)) dut (
    .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce),
    .req_valid_in(req_valid_in), .req_in(req_in),
    .req_ready_out(req_ready_out), .reject_out(reject_out),
    .suspend_in(suspend_in), .all_idle_out(all_idle_out),
    .pins_out(pins_out), .ba_out(ba_out), .addr_out(addr_out),
    .dqm_out(dqm_out), .cke_out(cke_out));
  sdram_model #(.BL(4)) mem (
    .clk_in(clk_in), .rst_in(rst_in), .pins_in(pins_out), .ba_in(ba_out),
    .ap_in(addr_out[sdram_pkg::AP_BIT]), .cke_in(cke_out), .viol_out(viol));
  task automatic stop_test();
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // valid stays up so back-to-back requests need no gap
  task automatic send(input sdram_pkg::op_t op, input int b, input bit a,
                      input sdram_pkg::pins_t p, input int lead);
    int n;
    n = 0;
    req_in = '{op, 2'(b), '0, a};
    req_valid_in = 1;
    while (req_ready_out !== 1'h1 && n < 400) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    if (p !== sdram_pkg::P_NOP) expq.push_back('{p, 2'(b), a, 2'(lead)});
    @(posedge clk_in);
    #1;
  endtask
  task automatic rej(input sdram_pkg::op_t op);
    rej_exp++;
    send(op, 0, 0, sdram_pkg::P_NOP, 0);
  endtask
  task automatic idle(input int n);
    req_valid_in = 0;
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic wait_cke(input logic v);
    int n;
    n = 0;
    req_valid_in = 0;
    while (cke_out !== v && n < 40) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    `CHK("cke", cke_out, v)
  endtask
  always @(negedge clk_in) begin
    if (!rst_in && !pins_out.cs_n && pins_out !== sdram_pkg::P_NOP) begin
      e = '1;
      if (expq.size() > 0) e = expq.pop_front();
      `CHK("pins", pins_out, e.pins)
      `CHK("bank", ba_out, e.bank)
      if (e.pins inside {sdram_pkg::P_RD, sdram_pkg::P_WR, sdram_pkg::P_PRE})
        `CHK("ap", addr_out[sdram_pkg::AP_BIT], e.ap)
      if (e.lead > 0) `CHK("dqm lead", dh[0], 1'h1)
      if (e.lead > 1) `CHK("dqm lead two", dh[1], 1'h1)
    end
    rej_seen += (reject_out === 1'h1);
    dh = {dh[0], dqm_out};
  end
  initial begin
    repeat (12) @(posedge clk_in);
    #1;
    `CHK("reset pins", pins_out, sdram_pkg::P_INH)
    `CHK("reset cke", cke_out, 1'h1)
    rst_in = 0;
    idle(2);
    for (int i = 0; i < 4; i++)
      send(sdram_pkg::op_act, i, 0, sdram_pkg::P_ACT, 0);
    idle(12);
    `CHK("busy", all_idle_out, 1'h0)
    rej(sdram_pkg::op_ref);
    rej(sdram_pkg::op_pdn);
    rej(sdram_pkg::op_bst);
    idle(4);
    send(sdram_pkg::op_rd, 0, 0, sdram_pkg::P_RD, 0);
    send(sdram_pkg::op_wr, 1, 0, sdram_pkg::P_WR, 1);
    send(sdram_pkg::op_rd, 2, 0, sdram_pkg::P_RD, 0);
    send(sdram_pkg::op_rd, 3, 1, sdram_pkg::P_RD, 0);
    send(sdram_pkg::op_wr, 0, 1, sdram_pkg::P_WR, 2);
    send(sdram_pkg::op_wr, 1, 0, sdram_pkg::P_WR, 0);
    send(sdram_pkg::op_pre, 2, 0, sdram_pkg::P_PRE, 0);
    send(sdram_pkg::op_pre, 1, 1, sdram_pkg::P_PRE, 0);
    idle(30);
    // frozen sequencer must keep driving nop
    ce = 0;
    idle(3);
    ce = 1;
    `CHK("idle", all_idle_out, 1'h1)
    send(sdram_pkg::op_lmr, 0, 0, sdram_pkg::P_LMR, 0);
    send(sdram_pkg::op_ref, 0, 0, sdram_pkg::P_REF, 0);
    send(sdram_pkg::op_pdn, 0, 0, sdram_pkg::P_NOP, 0);
    wait_cke(0);
    rej(sdram_pkg::op_act);
    send(sdram_pkg::op_wake, 0, 0, sdram_pkg::P_NOP, 0);
    wait_cke(1);
    send(sdram_pkg::op_act, 0, 0, sdram_pkg::P_ACT, 0);
    send(sdram_pkg::op_pre, 0, 0, sdram_pkg::P_PRE, 0);
    send(sdram_pkg::op_sref, 0, 0, sdram_pkg::P_REF, 0);
    wait_cke(0);
    send(sdram_pkg::op_wake, 0, 0, sdram_pkg::P_NOP, 0);
    wait_cke(1);
    send(sdram_pkg::op_act, 1, 0, sdram_pkg::P_ACT, 0);
    send(sdram_pkg::op_rd, 1, 0, sdram_pkg::P_RD, 0);
    suspend_in = 1;
    wait_cke(0);
    idle(3);
    suspend_in = 0;
    wait_cke(1);
    send(sdram_pkg::op_pre, 1, 0, sdram_pkg::P_PRE, 0);
    for (int i = 0; i < 8; i++) begin
      bk = 2'($random(seed));
      ap = 1'($random(seed));
      wr = 1'($random(seed));
      send(sdram_pkg::op_act, bk, 0, sdram_pkg::P_ACT, 0);
      send(wr ? sdram_pkg::op_wr : sdram_pkg::op_rd, bk, ap,
           wr ? sdram_pkg::P_WR : sdram_pkg::P_RD, 0);
      if (!ap) send(sdram_pkg::op_pre, bk, 0, sdram_pkg::P_PRE, 0);
    end
    idle(60);
    `CHK("queue left", expq.size(), 0)
    `CHK("rejects", rej_seen, rej_exp)
    `CHK("misuse", viol, 0)
    `CHK("end idle", all_idle_out, 1'h1)
    stop_test();
  end
  // run needs well under 1000 cycles; the 15000-cycle limit is ample
  initial begin
    #60000;
    errors++;
    stop_test();
  end
endmodule
